// >>> logic/fep_pkg.sv
// Constants and types for the fast Ethernet line coder and pause unit
package fep_pkg;
  localparam logic [7:0] REG_CTRL_OFF = 8'h00;
  localparam logic [7:0] REG_ADV_OFF = 8'h10;
  localparam logic [7:0] REG_STAT_OFF = 8'h40;
  localparam logic [7:0] REG_PART_OFF = 8'h44;
  localparam int CTRL_RESET_BIT = 15;
  localparam int CTRL_LOOP_BIT = 14;
  localparam int CTRL_SPEED_BIT = 13;
  localparam int CTRL_AN_BIT = 12;
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam logic [15:0] CTRL_RESET_VAL = 16'h3100;
  localparam logic [15:0] ADV_RESET_VAL = 16'h05e1;
  localparam int ADV_PAUSE_BIT = 10;
  localparam int ADV_100FD_BIT = 8;
  localparam int ADV_100HD_BIT = 7;
  localparam int ADV_10FD_BIT = 6;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0d;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [9:0] SCR_SEED = 10'h3ff;
  localparam logic [3:0] RX_LOCK_ONES = 4'he;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam int FLP_BITS = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_NS_100 = 10;
  localparam int BIT_NS_10 = 100;
  localparam int SLOT_BITS = 512;
  localparam int SLOT_CYC_100 = SLOT_BITS * BIT_NS_100 / CLK_PERIOD_NS;
  localparam int SLOT_CYC_10 = SLOT_BITS * BIT_NS_10 / CLK_PERIOD_NS;
  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fep_tx_t;
  typedef enum logic [1:0] {AN_IDLE, AN_FLP, AN_WAIT, AN_DONE} fep_an_t;
endpackage

// >>> logic/fep_core.sv
// Line coder, carrier logic, negotiation and pause timer
`timescale 1ns/1ps
`default_nettype none
module fep_core
  import fep_pkg::*;
#(
  parameter int SlotCycles10 = SLOT_CYC_10
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line side
  input wire logic lineClk,
  input wire logic rxMltPos,
  input wire logic rxMltNeg,
  output logic txMltPos,
  output logic txMltNeg,
  output logic flpBit,
  input wire logic partnerValid,
  input wire logic [15:0] partnerAbility,
  // Nibble side
  input wire logic txEn,
  input wire logic [3:0] txNibble,
  output logic txNibbleTake,
  output logic [3:0] rxNibble,
  output logic rxNibbleValid,
  output logic crs,
  output logic col,
  // MAC control side
  input wire logic ctrlFrameValid,
  input wire logic [15:0] ctrlOpcode,
  input wire logic [15:0] ctrlPauseTime,
  output logic txPermit
);
  function automatic logic [4:0] enc(input logic [3:0] n);
    case (n)
      4'h0: enc = 5'h1e;
      4'h1: enc = 5'h09;
      4'h2: enc = 5'h14;
      4'h3: enc = 5'h15;
      4'h4: enc = 5'h0a;
      4'h5: enc = 5'h0b;
      4'h6: enc = 5'h0e;
      4'h7: enc = 5'h0f;
      4'h8: enc = 5'h12;
      4'h9: enc = 5'h13;
      4'ha: enc = 5'h16;
      4'hb: enc = 5'h17;
      4'hc: enc = 5'h1a;
      4'hd: enc = 5'h1b;
      4'he: enc = 5'h1c;
      default: enc = 5'h1d;
    endcase
  endfunction

  function automatic logic [3:0] dec(input logic [4:0] g);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (enc(4'(i)) == g)
        r = 4'(i);
    end
    dec = r;
  endfunction

  function automatic logic sepZeros(input logic [9:0] w);
    logic f;
    f = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      for (int j = i + 2; j < 10; j++)
      begin
        if (!w[i] && !w[j])
          f = 1'b1;
      end
    end
    sepZeros = f;
  endfunction

  // Pin synchronisers
  logic [4:0] syncA_reg, syncB_reg;
  logic lineClkPrev_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      syncA_reg <= 5'h00;
      syncB_reg <= 5'h00;
      lineClkPrev_reg <= 1'b0;
    end
    else
    begin
      syncA_reg <= {partnerValid, rxMltNeg, rxMltPos, lineClk, 1'b0};
      syncB_reg <= syncA_reg;
      lineClkPrev_reg <= syncB_reg[1];
    end
  end
  logic tick;
  assign tick = syncB_reg[1] && !lineClkPrev_reg;

  // Registers
  logic [15:0] ctrl_reg, adv_reg, partner_reg;
  logic [31:0] status;
  logic wrEn, anStart;
  assign wrEn = psel && penable && pwrite;
  assign pready = 1'b1;
  assign anStart = wrEn && paddr == REG_CTRL_OFF
    && pwdata[CTRL_AN_BIT] && !ctrl_reg[CTRL_AN_BIT];
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= CTRL_RESET_VAL;
      adv_reg <= ADV_RESET_VAL;
    end
    else if (wrEn && paddr == REG_CTRL_OFF && pwdata[CTRL_RESET_BIT])
    begin
      // Self-clearing soft reset of the coder registers
      ctrl_reg <= CTRL_RESET_VAL;
      adv_reg <= ADV_RESET_VAL;
    end
    else if (wrEn && paddr == REG_CTRL_OFF)
      ctrl_reg <= {1'b0, pwdata[14:0]};
    else if (wrEn && paddr == REG_ADV_OFF)
      adv_reg <= pwdata[15:0];
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= 1'b0;
      case (paddr)
        REG_CTRL_OFF: prdata <= {16'h0, ctrl_reg};
        REG_ADV_OFF: prdata <= {16'h0, adv_reg};
        REG_STAT_OFF: prdata <= status;
        REG_PART_OFF: prdata <= {16'h0, partner_reg};
        default:
        begin
          prdata <= 32'h0;
          pslverr <= 1'b1;
        end
      endcase
    end
  end
  logic loopback;
  assign loopback = ctrl_reg[CTRL_LOOP_BIT];

  // Scrambler, one step per bit tick
  logic [9:0] lfsr_reg, lfsrPrev_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lfsr_reg <= SCR_SEED;
      lfsrPrev_reg <= SCR_SEED;
    end
    else if (tick)
    begin
      lfsr_reg <= {lfsr_reg[8:0], lfsr_reg[9] ^ lfsr_reg[6]};
      lfsrPrev_reg <= lfsr_reg;
    end
  end

  // Transmit group builder and serialiser
  fep_tx_t txState_reg;
  logic [4:0] txShift_reg;
  logic [2:0] bitCnt_reg;
  logic txActive, groupEnd, scrBit;
  assign groupEnd = tick && bitCnt_reg == 3'd4;
  assign txActive = txState_reg != TX_IDLE;
  assign scrBit = txShift_reg[4] ^ lfsr_reg[9];
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txState_reg <= TX_IDLE;
      txShift_reg <= CG_IDLE;
      bitCnt_reg <= 3'd0;
      txNibbleTake <= 1'b0;
    end
    else
    begin
      txNibbleTake <= 1'b0;
      if (groupEnd)
      begin
        bitCnt_reg <= 3'd0;
        case (txState_reg)
          TX_IDLE:
            if (txEn)
            begin
              txShift_reg <= CG_J;
              txNibbleTake <= 1'b1;
              txState_reg <= TX_K;
            end
            else
              txShift_reg <= CG_IDLE;
          TX_K:
          begin
            txShift_reg <= CG_K;
            txNibbleTake <= 1'b1;
            txState_reg <= TX_DATA;
          end
          TX_DATA:
            if (txEn)
            begin
              txShift_reg <= enc(txNibble);
              txNibbleTake <= 1'b1;
            end
            else
            begin
              txShift_reg <= CG_T;
              txState_reg <= TX_R;
            end
          TX_R:
          begin
            txShift_reg <= CG_R;
            txState_reg <= TX_IDLE;
          end
          default: txState_reg <= TX_IDLE;
        endcase
      end
      else if (tick)
      begin
        txShift_reg <= {txShift_reg[3:0], 1'b0};
        bitCnt_reg <= bitCnt_reg + 3'd1;
      end
    end
  end

  // NRZI and MLT3 line encoder
  logic txNrzi_reg, lineNrzi_reg;
  logic [1:0] mltStep_reg;
  logic lineBit;
  // Loopback keeps the line alive with unscrambled ones only
  assign lineBit = loopback ? 1'b1 : scrBit;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txNrzi_reg <= 1'b0;
      lineNrzi_reg <= 1'b0;
      mltStep_reg <= 2'd0;
      txMltPos <= 1'b0;
      txMltNeg <= 1'b0;
    end
    else if (tick)
    begin
      txNrzi_reg <= txNrzi_reg ^ scrBit;
      lineNrzi_reg <= lineNrzi_reg ^ lineBit;
      if (lineBit)
      begin
        mltStep_reg <= mltStep_reg + 2'd1;
        txMltPos <= mltStep_reg == 2'd0;
        txMltNeg <= mltStep_reg == 2'd2;
      end
    end
  end

  // Receive: MLT3 to NRZI to NRZ, descramble, pack
  logic [1:0] rxMltPrev_reg;
  logic rxNrziLine_reg, rxNrziPrev_reg, rxNrziSel, rxBit;
  logic [9:0] rxWin_reg;
  logic carrier_reg, aligned_reg;
  logic [2:0] rxCnt_reg;
  // Loopback at either speed shares this same inner path
  assign rxNrziSel = loopback ? txNrzi_reg : rxNrziLine_reg;
  logic rxNrz, rxKeyPred, rxKey, rxLocked_reg;
  logic [9:0] rxLfsr_reg;
  logic [3:0] lockCnt_reg;
  assign rxNrz = rxNrziSel ^ rxNrziPrev_reg;
  assign rxKeyPred = rxLfsr_reg[9] ^ rxLfsr_reg[6];
  // Line key is learned from idle; loopback reuses the local key
  assign rxKey = loopback ? lfsrPrev_reg[9] : rxKeyPred;
  assign rxBit = rxNrz ^ rxKey;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxLfsr_reg <= SCR_SEED;
      lockCnt_reg <= 4'h0;
      rxLocked_reg <= 1'b0;
    end
    else if (tick)
    begin
      rxLfsr_reg <= {rxLfsr_reg[8:0], rxLocked_reg ? rxKeyPred : !rxNrz};
      if (!rxLocked_reg)
      begin
        if (rxBit)
        begin
          lockCnt_reg <= lockCnt_reg + 4'h1;
          if (lockCnt_reg == RX_LOCK_ONES)
            rxLocked_reg <= 1'b1;
        end
        else
          lockCnt_reg <= 4'h0;
      end
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxMltPrev_reg <= 2'd0;
      rxNrziLine_reg <= 1'b0;
      rxNrziPrev_reg <= 1'b0;
      rxWin_reg <= 10'h3ff;
    end
    else if (tick)
    begin
      rxMltPrev_reg <= syncB_reg[3:2];
      if (syncB_reg[3:2] != rxMltPrev_reg)
        rxNrziLine_reg <= !rxNrziLine_reg;
      rxNrziPrev_reg <= rxNrziSel;
      rxWin_reg <= {rxWin_reg[8:0], rxBit};
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      carrier_reg <= 1'b0;
      aligned_reg <= 1'b0;
      rxCnt_reg <= 3'd0;
      rxNibble <= 4'h0;
      rxNibbleValid <= 1'b0;
    end
    else
    begin
      rxNibbleValid <= 1'b0;
      if (tick)
      begin
        rxCnt_reg <= rxCnt_reg == 3'd4 ? 3'd0 : rxCnt_reg + 3'd1;
        // No carrier until the descrambler has locked on idle, except in loopback
        if (!carrier_reg && (rxLocked_reg || loopback)
          && sepZeros(rxWin_reg))
          carrier_reg <= 1'b1;
        if (rxWin_reg == {CG_J, CG_K})
        begin
          aligned_reg <= 1'b1;
          rxCnt_reg <= 3'd1;
        end
        else if (aligned_reg && rxCnt_reg == 3'd0)
        begin
          if (rxWin_reg[4:0] == CG_T || rxWin_reg[4:0] == CG_IDLE)
          begin
            carrier_reg <= 1'b0;
            aligned_reg <= 1'b0;
          end
          else
          begin
            rxNibble <= dec(rxWin_reg[4:0]);
            rxNibbleValid <= 1'b1;
          end
        end
      end
    end
  end

  // Auto-negotiation
  fep_an_t anState_reg;
  logic [15:0] flpShift_reg;
  logic [4:0] flpCnt_reg;
  logic [15:0] common;
  logic anDone, speed100, fullDuplex, pauseEn;
  assign common = adv_reg & partner_reg;
  assign anDone = anState_reg == AN_DONE;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      anState_reg <= AN_IDLE;
      flpShift_reg <= 16'h0;
      flpCnt_reg <= 5'd0;
      partner_reg <= 16'h0;
      flpBit <= 1'b0;
    end
    else
    begin
      case (anState_reg)
        AN_IDLE:
          if (ctrl_reg[CTRL_AN_BIT] || anStart)
          begin
            flpShift_reg <= adv_reg;
            flpCnt_reg <= 5'd0;
            anState_reg <= AN_FLP;
          end
        AN_FLP:
          if (tick)
          begin
            flpBit <= flpShift_reg[0];
            flpShift_reg <= {1'b0, flpShift_reg[15:1]};
            flpCnt_reg <= flpCnt_reg + 5'd1;
            if (flpCnt_reg == 5'(FLP_BITS - 1))
              anState_reg <= AN_WAIT;
          end
        AN_WAIT:
          if (syncB_reg[4])
          begin
            partner_reg <= partnerAbility;
            anState_reg <= AN_DONE;
          end
        AN_DONE:
          if (!ctrl_reg[CTRL_AN_BIT])
            anState_reg <= AN_IDLE;
        default: anState_reg <= AN_IDLE;
      endcase
    end
  end
  always_comb
  begin
    if (!ctrl_reg[CTRL_AN_BIT] || !anDone)
    begin
      speed100 = ctrl_reg[CTRL_SPEED_BIT];
      fullDuplex = ctrl_reg[CTRL_DUPLEX_BIT];
    end
    else
    begin
      speed100 = common[ADV_100FD_BIT] || common[ADV_100HD_BIT];
      fullDuplex = common[ADV_100FD_BIT] || (!common[ADV_100HD_BIT]
        && common[ADV_10FD_BIT]);
    end
  end
  assign pauseEn = anDone && fullDuplex && common[ADV_PAUSE_BIT];

  // Carrier sense and collision by duplex
  assign crs = fullDuplex ? carrier_reg : carrier_reg || txActive;
  assign col = !fullDuplex && carrier_reg && txActive;

  // Pause timer in slot times
  logic [15:0] pauseCnt_reg;
  logic [12:0] slotCnt_reg;
  logic paused, pauseHit;
  logic [12:0] slotMax;
  assign slotMax = speed100 ? 13'(SLOT_CYC_100 - 1)
    : 13'(SlotCycles10 - 1);
  assign pauseHit = ctrlFrameValid && ctrlOpcode == PAUSE_OPCODE
    && pauseEn;
  assign paused = pauseCnt_reg != 16'h0;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pauseCnt_reg <= 16'h0;
      slotCnt_reg <= 13'd0;
    end
    else if (pauseHit)
    begin
      pauseCnt_reg <= ctrlPauseTime;
      slotCnt_reg <= 13'd0;
    end
    else if (paused)
    begin
      if (slotCnt_reg == slotMax)
      begin
        slotCnt_reg <= 13'd0;
        pauseCnt_reg <= pauseCnt_reg - 16'd1;
      end
      else
        slotCnt_reg <= slotCnt_reg + 13'd1;
    end
  end
  // Only new starts are gated; a frame under way keeps going
  assign txPermit = !paused && !pauseHit;

  assign status = {24'h0, loopback, pauseEn, fullDuplex, speed100,
    anDone, paused, col, carrier_reg};

  a_col_full_duplex: assert property (@(posedge clk) disable iff (rst)
    fullDuplex |-> !col) else $error("collision in full duplex");
  a_crs_half_tx: assert property (@(posedge clk) disable iff (rst)
    !fullDuplex && txActive |-> crs) else $error("no crs on tx");
  a_pause_load_time: assert property (@(posedge clk) disable iff (rst)
    pauseHit && ctrlPauseTime != 16'h0 |=> paused
    && pauseCnt_reg == $past(ctrlPauseTime))
    else $error("pause time not loaded");
  a_pause_zero_ends: assert property (@(posedge clk) disable iff (rst)
    pauseHit && ctrlPauseTime == 16'h0 |=> !paused)
    else $error("zero pause kept pause");
  a_pause_gates_start: assert property (@(posedge clk) disable iff (rst)
    paused |-> !txPermit) else $error("start permitted in pause");
  a_pause_enable: assert property (@(posedge clk) disable iff (rst)
    pauseEn |-> anDone && fullDuplex) else $error("pause enabled early");
  a_loop_write: assert property (@(posedge clk) disable iff (rst)
    wrEn && paddr == REG_CTRL_OFF && pwdata[CTRL_RESET_BIT:CTRL_LOOP_BIT]
    == 2'b01 |=> loopback) else $error("loopback not set");
  a_an_priority: assert property (@(posedge clk) disable iff (rst)
    ctrl_reg[CTRL_AN_BIT] && anDone && common[ADV_100FD_BIT]
    |-> speed100 && fullDuplex) else $error("wrong mode picked");
  a_an_forced_mode: assert property (@(posedge clk) disable iff (rst)
    !ctrl_reg[CTRL_AN_BIT] |-> speed100 == ctrl_reg[CTRL_SPEED_BIT])
    else $error("forced speed ignored");
endmodule
`default_nettype wire

// >>> verif/fep_link_partner.sv
// Remote link partner model: line clock, idle line and ability word
`timescale 1ns/1ps
`default_nettype none
module fep_link_partner #(
  parameter int HalfNs = 80,
  parameter int ValidDelay = 3
)(
  // Bench control
  input wire logic offer,
  input wire logic [15:0] offerWord,
  // Line side
  output logic lineClk,
  output logic rxMltPos,
  output logic rxMltNeg,
  output logic partnerValid,
  output logic [15:0] partnerAbility
);
  logic [1:0] phase = 2'd0;
  int waitCnt = 0;
  initial
  begin
    lineClk = 1'b0;
    partnerValid = 1'b0;
    partnerAbility = 16'h0000;
    #37;
    forever
      #(HalfNs) lineClk = ~lineClk;
  end
  logic [9:0] key = 10'h3ff;
  // Scrambled idle: a one steps the three-level code
  always @(negedge lineClk)
  begin
    key <= {key[8:0], key[9] ^ key[6]};
    if (!key[9])
      phase <= phase + 2'd1;
  end
  assign rxMltPos = (phase == 2'd1);
  assign rxMltNeg = (phase == 2'd3);
  // Word settles before valid rises; a withdrawn word is inverted
  always @(posedge lineClk)
  begin
    if (!offer)
    begin
      partnerValid <= 1'b0;
      partnerAbility <= ~offerWord;
      waitCnt <= 0;
    end
    else
    begin
      partnerAbility <= offerWord;
      if (waitCnt == ValidDelay)
        partnerValid <= 1'b1;
      else
        waitCnt <= waitCnt + 1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/fep_core_bench.sv
// Self-checking bench for the line coder, negotiation and pause unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    checksDone++; \
    if ((gt) !== (ex)) \
    begin \
      errorCnt++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module fep_core_bench
  import fep_pkg::*;
;
  localparam int Slot10 = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, dq;
  logic pready, pslverr, lineClk, rxMltPos, rxMltNeg, txMltPos, txMltNeg;
  logic flpBit, partnerValid, txNibbleTake, rxNibbleValid, crs, col, txPermit;
  logic [15:0] partnerAbility;
  logic [3:0] rxNibble;
  logic txEn = 1'b0;
  logic [3:0] txNibble = 4'h0;
  logic ctrlFrameValid = 1'b0;
  logic [15:0] ctrlOpcode = 16'h0000;
  logic [15:0] ctrlPauseTime = 16'h0000;
  logic offer = 1'b1;
  logic [15:0] offerWord = 16'h0501;
  logic [32:0] rdExp[$];
  logic [31:0] rdMask[$];
  logic [3:0] rxExp[$];
  logic [15:0] advTab[5] = '{16'h05e1, 16'h05e1, 16'h05e1, 16'h05e1, 16'h0061};
  logic [15:0] parTab[5] = '{16'h0501, 16'h0081, 16'h0441, 16'h0021, 16'h05e1};
  logic [1:0] lastLine = 2'b00;
  logic lastClk = 1'b0;
  logic lineWatch = 1'b0;
  logic midCrs, midCol, permitNow;
  int errorCnt = 0;
  int checksDone = 0;
  int seed = 84512;
  int cycles = 0;
  int badMlt = 0;
  int chgCnt = 0;
  int tickCnt = 0;
  int gapMin, gapMax;

  always #5 clk = ~clk;

  fep_core #(.SlotCycles10(Slot10)) dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lineClk(lineClk), .rxMltPos(rxMltPos),
    .rxMltNeg(rxMltNeg), .txMltPos(txMltPos), .txMltNeg(txMltNeg),
    .flpBit(flpBit), .partnerValid(partnerValid),
    .partnerAbility(partnerAbility), .txEn(txEn), .txNibble(txNibble),
    .txNibbleTake(txNibbleTake), .rxNibble(rxNibble),
    .rxNibbleValid(rxNibbleValid), .crs(crs), .col(col),
    .ctrlFrameValid(ctrlFrameValid), .ctrlOpcode(ctrlOpcode),
    .ctrlPauseTime(ctrlPauseTime), .txPermit(txPermit)
  );
  fep_link_partner peer (
    .offer(offer), .offerWord(offerWord), .lineClk(lineClk),
    .rxMltPos(rxMltPos), .rxMltNeg(rxMltNeg), .partnerValid(partnerValid),
    .partnerAbility(partnerAbility)
  );

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Zero wait states, but the master still waits on pready
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d}, dq);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] ex,
      input logic [31:0] m);
    rdExp.push_back(ex);
    rdMask.push_back(m);
    apb(1'b0, a, 32'h0, dq);
  endtask

  task automatic waitAn();
    int n;
    dq = 32'h0;
    n = 0;
    while (dq[3] !== 1'b1 && n < 2000)
    begin
      apb(1'b0, REG_STAT_OFF, 32'h0, dq);
      n++;
    end
  endtask

  task automatic pulse(input logic [15:0] op, input logic [15:0] t);
    @(posedge clk);
    ctrlFrameValid <= 1'b1;
    ctrlOpcode <= op;
    ctrlPauseTime <= t;
    #1;
    permitNow = txPermit;
    @(posedge clk);
    ctrlFrameValid <= 1'b0;
  endtask

  task automatic pauseChk(input logic [15:0] op, input logic [15:0] t,
      input logic pe, input int slot);
    logic hit;
    int n;
    hit = pe && op == PAUSE_OPCODE && t != 16'h0;
    pulse(op, t);
    `CHK("permit at frame", !hit, permitNow)
    repeat (hit ? t * slot - 3 : 4) @(posedge clk);
    #1;
    `CHK("permit held", !hit, txPermit)
    n = 0;
    while (txPermit !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("permit back", 1'b1, txPermit)
  endtask

  // Next nibble is offered as soon as the last one is taken
  task automatic sendFrame(input int len, input logic loop);
    logic [3:0] nib;
    int n;
    gapMin = 999;
    gapMax = 0;
    for (int i = 0; i < len; i++)
    begin
      nib = 4'($random(seed));
      txEn <= 1'b1;
      txNibble <= nib;
      if (loop && i >= 2)
        rxExp.push_back(nib);
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (txNibbleTake !== 1'b1 && n < 200);
      if (i > 0)
      begin
        gapMin = (n < gapMin) ? n : gapMin;
        gapMax = (n > gapMax) ? n : gapMax;
      end
      if (i == len / 2)
      begin
        midCrs = crs;
        midCol = col;
      end
    end
    txEn <= 1'b0;
    repeat (600) @(posedge clk);
    `CHK("group spacing", 1'b1, gapMin >= 76 && gapMax <= 84)
  endtask

  always @(posedge clk)
  begin : watch
    logic [32:0] ex;
    logic [31:0] m;
    logic [3:0] rx;
    logic [1:0] ln;
    cycles++;
    ln = {txMltPos, txMltNeg};
    if (psel && penable && pready === 1'b1 && !pwrite && rdExp.size() > 0)
    begin
      ex = rdExp.pop_front();
      m = rdMask.pop_front();
      `CHK("read data", ex, {pslverr, prdata & m})
    end
    if (rxNibbleValid === 1'b1 && lineWatch)
    begin
      rx = (rxExp.size() > 0) ? rxExp.pop_front() : 4'hx;
      `CHK("rx nibble", rx, rxNibble)
    end
    // Three-level code never jumps straight between the outer levels
    if ((lastLine ^ ln) == 2'b11 || ln == 2'b11)
      badMlt++;
    if (lineWatch && ln != lastLine)
      chgCnt++;
    if (lineWatch && lineClk && !lastClk)
      tickCnt++;
    lastLine = ln;
    lastClk = lineClk;
    if (cycles == 90000)
    begin
      errorCnt++;
      $display("[ERR] cycle limit expected %0d seen %0d", 90000, cycles);
      stop_test();
    end
  end

  initial
  begin : main
    logic [15:0] cm;
    logic spd, fd, pe;
    logic [15:0] t;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(REG_CTRL_OFF, {1'b0, 32'h00003100}, 32'hffffffff);
    rd(REG_ADV_OFF, {1'b0, 32'h000005e1}, 32'hffffffff);
    rd(8'h20, {1'b1, 32'h0}, 32'hffffffff);
    $display("Test registers done");
    for (int k = 0; k < 5; k++)
    begin
      offer <= 1'b0;
      wr(REG_CTRL_OFF, 16'h0000);
      wr(REG_ADV_OFF, advTab[k]);
      repeat (40) @(posedge clk);
      rd(REG_STAT_OFF, {1'b0, 32'h0}, 32'h38);
      offerWord <= parTab[k];
      offer <= 1'b1;
      wr(REG_CTRL_OFF, 16'h1000);
      waitAn();
      cm = advTab[k] & parTab[k];
      spd = cm[8] | cm[7];
      fd = cm[8] | (!cm[7] & cm[6]);
      pe = fd & cm[10];
      rd(REG_STAT_OFF, {26'h0, pe, fd, spd, 4'h8}, 32'h78);
      wr(REG_PART_OFF, 16'hffff);
      rd(REG_PART_OFF, {17'h0, parTab[k]}, 32'hffffffff);
      t = 16'h1 + 16'($random(seed) & 32'h1);
      pauseChk(16'h0002, 16'h0003, pe, 512);
      pauseChk(PAUSE_OPCODE, t, pe, spd ? 512 : Slot10);
      if (k == 0)
      begin
        pulse(PAUSE_OPCODE, 16'h0003);
        repeat (20) @(posedge clk);
        #1;
        `CHK("paused", 1'b0, txPermit)
        pulse(PAUSE_OPCODE, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        `CHK("zero pause", 1'b1, txPermit)
      end
    end
    $display("Test negotiation and pause done");
    wr(REG_CTRL_OFF, 16'h2100);
    rd(REG_STAT_OFF, {1'b0, 32'h30}, 32'h38);
    sendFrame(10, 1'b0);
    `CHK("crs full tx", 1'b0, midCrs)
    `CHK("col full", 1'b0, midCol)
    wr(REG_CTRL_OFF, 16'h2000);
    sendFrame(10, 1'b0);
    `CHK("crs half tx", 1'b1, midCrs)
    `CHK("col half", 1'b0, midCol)
    $display("Test line frames done");
    wr(REG_CTRL_OFF, 16'h6100);
    lineWatch <= 1'b1;
    sendFrame(16, 1'b1);
    lineWatch <= 1'b0;
    @(posedge clk);
    `CHK("rx drained", 0, rxExp.size())
    `CHK("idle line", 1'b1, chgCnt + 2 >= tickCnt && chgCnt <= tickCnt + 2)
    `CHK("crs loop", 1'b1, midCrs)
    `CHK("mlt3 steps", 0, badMlt)
    $display("Test loopback done");
    stop_test();
  end
endmodule
`default_nettype wire
